// *** rtl/tmr_timer16.sv ***
// 16-bit timer/event counter with one-shot pulse, capture and AHB-Lite register slave
// Notes on behaviour
// - pin trigger clears and starts counter; pulse on at B match, off at A match
// - with B above A the pulse runs from A match to B match; never equal
// - trigger edge is rising, falling or both, from prescaler bits 4 and 5
// - trigger edges during a pulse are ignored and never restart the counter
// - counting starts as soon as the run mode is not stop
// - first match after start may come up to one count clock late
// - compare register contents are not guaranteed after a stop
// - in software one-shot mode the trigger pin still clears and starts
// - counter wrap from maximum to zero sets the overflow flag
// - clearing overflow before the count reaches one has no effect
// - capture wins over a simultaneous write of the capture register
// - reading the counter never captures into compare_reg_b
// - pins are ignored while the timer is stopped
// - one-shot works only in free-running and edge-clear modes
// - no capture from the trigger pin when it is the count clock
// - capture at the count clock, capture event one count clock later
// - a high pin after reset gives a rising edge at first start only
// - pins need the valid level twice; sample rate fx or prescaler clock
// - counter keeps running after a one-shot until stopped
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_timer16 (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        trigger_in_pin,
  input  wire logic        capture_in_b_pin,
  output logic             pulse_out_pin,
  output logic             match_a_irq,
  output logic             match_b_irq
);
  logic [15:0]       main_counter;
  logic [15:0]       compare_reg_a;
  logic [15:0]       compare_reg_b;
  logic [7:0]        timer_mode_reg;
  logic [7:0]        capture_compare_ctrl_reg;
  logic [7:0]        output_control_reg;
  logic [7:0]        prescaler_reg;
  logic              overflow_flag;
  logic              ovf_hold;
  logic              wr_pend;
  logic [2:0]        wr_idx;
  logic              soft_oneshot_trigger;
  logic [3:0]        div_cnt;
  logic              ever_ran;
  logic [1:0]        sync1;
  logic [1:0]        sync2;
  logic [1:0]        smp_a;
  logic [1:0]        smp_b;
  logic [1:0]        flt;
  logic [1:0]        prv;
  logic [1:0]        cap_pend;
  tmr_pkg::tmr_os_t  os_state;
  tmr_pkg::tmr_run_t run_mode;
  tmr_pkg::tmr_clk_t clk_sel;
  logic              run;
  logic              pre_tick;
  logic              tick;
  logic [1:0]        smp_en;
  logic              trg_edge;
  logic              capb_edge;
  logic              trg_v;
  logic              os_fire;
  logic              mt_a;
  logic              mt_b;
  logic              cap_a;
  logic              cap_b;
  logic              ovf_evt;
  logic              bus_take;
  logic              ovf_clr;
  // edge qualifier: 00 falling, 01 rising, 1x both
  function automatic logic edge_ok(input logic [1:0] sel, input logic now, input logic old);
    if (sel == 2'h0) begin
      return old & ~now;
    end else if (sel == 2'h1) begin
      return now & ~old;
    end
    return now ^ old;
  endfunction
  // register write strobe for one index, in the data phase
  function automatic logic wr_hit(input logic p, input logic [2:0] i, input logic [2:0] k);
    return p && (i == k);
  endfunction

  assign run_mode = tmr_pkg::tmr_run_t'(timer_mode_reg[`TMR_RUN_HI:`TMR_RUN_LO]);
  assign clk_sel  = tmr_pkg::tmr_clk_t'(prescaler_reg[`TMR_PRE_CLK_HI:`TMR_PRE_CLK_LO]);
  assign run      = (run_mode != tmr_pkg::RUN_STOP);

  // prescaler is free-running, so the first count after start lands anywhere in a period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // prescale tick: every cycle at fx and with the pin clock, else the last count of the divider
  assign pre_tick = (clk_sel == tmr_pkg::CLK_DIV4)  ? (div_cnt[1:0] == `TMR_DIV4_LAST) :
                    (clk_sel == tmr_pkg::CLK_DIV16) ? (div_cnt == `TMR_DIV16_LAST) : 1'b1;

  // two-stage synchronisers, bit 0 trigger pin, bit 1 capture pin
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= (g == 0) ? trigger_in_pin : capture_in_b_pin;
          sync2[g] <= sync1[g];
        end
      end
      // noise filter: level accepted only after two equal samples
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          smp_a[g] <= 1'b0;
          smp_b[g] <= 1'b0;
          flt[g]   <= 1'b0;
        end else if (smp_en[g]) begin
          smp_a[g] <= sync2[g];
          smp_b[g] <= smp_a[g];
          if (smp_a[g] == smp_b[g]) begin
            flt[g] <= smp_b[g];
          end
        end
      end
      // previous level stays low until the first start, then tracks even while stopped
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prv[g] <= 1'b0;
        end else if (run || ever_ran) begin
          prv[g] <= flt[g];
        end
      end
    end
  endgenerate

  // trigger pin samples at fx when it is the count clock, else at the prescaler rate
  assign smp_en[0] = (clk_sel == tmr_pkg::CLK_PIN_EDGE) ? 1'b1 : pre_tick;
  assign smp_en[1] = pre_tick;
  // edges count only while running
  assign trg_edge  = run && edge_ok(prescaler_reg[`TMR_PRE_ES_HI:`TMR_PRE_ES_LO], flt[0], prv[0]);
  assign capb_edge = run && edge_ok(prescaler_reg[`TMR_PRE_ESB_HI:`TMR_PRE_ESB_LO], flt[1], prv[1]);
  assign trg_v     = trg_edge && (clk_sel != tmr_pkg::CLK_PIN_EDGE);
  assign tick      = run && ((clk_sel == tmr_pkg::CLK_PIN_EDGE) ? trg_edge : pre_tick);
  // remembers the first start, so a restart after a stop sees no false edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ever_ran <= 1'b0;
    end else if (run) begin
      ever_ran <= 1'b1;
    end
  end

  // one-shot fires from software or pin, never in match-clear mode and never while busy
  assign os_fire = run && output_control_reg[`TMR_OUT_OS_EN]
                   && (run_mode != tmr_pkg::RUN_MATCH_CLR)
                   && (os_state == tmr_pkg::OS_IDLE)
                   && (soft_oneshot_trigger || trg_v);
  assign mt_a    = tick && (main_counter == compare_reg_a);
  assign mt_b    = tick && (main_counter == compare_reg_b);
  assign ovf_evt = tick && (main_counter == `TMR_CNT_MAX);
  // main counter; held at zero while stopped; an edge during a one-shot must not restart it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_counter <= 16'h0000;
    end else if (!run) begin
      main_counter <= 16'h0000;
    end else if (os_fire) begin
      main_counter <= 16'h0000;
    end else if ((run_mode == tmr_pkg::RUN_EDGE_CLR) && trg_v && (os_state == tmr_pkg::OS_IDLE)) begin
      main_counter <= 16'h0000;
    end else if (tick) begin
      if ((run_mode == tmr_pkg::RUN_MATCH_CLR) && (main_counter == compare_reg_a)) begin
        main_counter <= 16'h0000;
      end else begin
        main_counter <= main_counter + 16'h0001;
      end
    end
  end

  // one-shot sequence; the lower compare value switches the pulse on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      os_state      <= tmr_pkg::OS_IDLE;
      pulse_out_pin <= 1'b0;
    end else if (!run) begin
      os_state      <= tmr_pkg::OS_IDLE;
      pulse_out_pin <= 1'b0;
    end else begin
      case (os_state)
        tmr_pkg::OS_IDLE: begin
          if (os_fire) begin
            os_state <= tmr_pkg::OS_WAIT;
          end
        end
        tmr_pkg::OS_WAIT: begin
          if ((compare_reg_b < compare_reg_a) ? mt_b : mt_a) begin
            os_state      <= tmr_pkg::OS_ACTIVE;
            pulse_out_pin <= output_control_reg[`TMR_OUT_EN];
          end
        end
        default: begin
          if ((compare_reg_b < compare_reg_a) ? mt_a : mt_b) begin
            os_state      <= tmr_pkg::OS_IDLE;
            pulse_out_pin <= 1'b0;
          end
        end
      endcase
    end
  end

  // captures; the trigger pin cannot capture when it is the count clock
  assign cap_b = trg_v && capture_compare_ctrl_reg[`TMR_CRC_CAP_B];
  assign cap_a = capb_edge && capture_compare_ctrl_reg[`TMR_CRC_CAP_A];

  // capture has priority over a register write in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_reg_a <= `TMR_CMP_RESET;
    end else if (cap_a) begin
      compare_reg_a <= main_counter;
    end else if (wr_hit(wr_pend, wr_idx, `TMR_IDX_CMP_A)) begin
      compare_reg_a <= hwdata[15:0];
    end
  end

  // a trigger edge or a bus write loads this register; bus reads have no side effect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_reg_b <= `TMR_CMP_RESET;
    end else if (cap_b) begin
      compare_reg_b <= main_counter;
    end else if (wr_hit(wr_pend, wr_idx, `TMR_IDX_CMP_B)) begin
      compare_reg_b <= hwdata[15:0];
    end
  end

  // capture event is raised one count clock after the capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_pend <= 2'h0;
    end else if (!run) begin
      cap_pend <= 2'h0;
    end else begin
      cap_pend[0] <= cap_a | (cap_pend[0] & ~tick);
      cap_pend[1] <= cap_b | (cap_pend[1] & ~tick);
    end
  end

  // match events in compare mode, capture events in capture mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      match_a_irq <= capture_compare_ctrl_reg[`TMR_CRC_CAP_A] ? (tick & cap_pend[0] & ~cap_a) : mt_a;
      match_b_irq <= capture_compare_ctrl_reg[`TMR_CRC_CAP_B] ? (tick & cap_pend[1] & ~cap_b) : mt_b;
    end
  end

  // overflow stays forced until the counter leaves zero, so an early clear is lost
  assign ovf_clr = wr_hit(wr_pend, wr_idx, `TMR_IDX_STATUS) && hwdata[`TMR_ST_OVF];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_hold      <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      ovf_hold <= ovf_evt | (ovf_hold & ~tick & run);
      if (ovf_evt || ovf_hold) begin
        overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_mode_reg           <= 8'h00;
      capture_compare_ctrl_reg <= 8'h00;
      output_control_reg       <= 8'h00;
      prescaler_reg            <= 8'h00;
    end else begin
      if (wr_hit(wr_pend, wr_idx, `TMR_IDX_MODE)) begin
        timer_mode_reg <= hwdata[7:0] & 8'h0C;
      end
      if (wr_hit(wr_pend, wr_idx, `TMR_IDX_CRC)) begin
        capture_compare_ctrl_reg <= hwdata[7:0] & 8'h03;
      end
      if (wr_hit(wr_pend, wr_idx, `TMR_IDX_OUTC)) begin
        output_control_reg <= hwdata[7:0] & 8'h11; // trigger bit is not stored
      end
      if (wr_hit(wr_pend, wr_idx, `TMR_IDX_PRESC)) begin
        prescaler_reg <= hwdata[7:0] & 8'hF3;
      end
    end
  end

  // software trigger is a one-cycle pulse from the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_oneshot_trigger <= 1'b0;
    end else begin
      soft_oneshot_trigger <= wr_hit(wr_pend, wr_idx, `TMR_IDX_OUTC) && hwdata[`TMR_OUT_SOFT];
    end
  end

  // bus slave: zero wait states, always OKAY
  assign bus_take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_idx    <= 3'h0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= bus_take && hwrite && (haddr[31:5] == 27'h0);
      wr_idx  <= haddr[4:2];
      hrdata  <= 32'h0000_0000;
      if (bus_take && !hwrite && (haddr[31:5] == 27'h0)) begin
        if (haddr[4:2] == `TMR_IDX_COUNT) begin
          hrdata <= {16'h0000, main_counter};
        end else if (haddr[4:2] == `TMR_IDX_CMP_A) begin
          hrdata <= {16'h0000, compare_reg_a};
        end else if (haddr[4:2] == `TMR_IDX_CMP_B) begin
          hrdata <= {16'h0000, compare_reg_b};
        end else if (haddr[4:2] == `TMR_IDX_MODE) begin
          hrdata <= {24'h000000, timer_mode_reg};
        end else if (haddr[4:2] == `TMR_IDX_CRC) begin
          hrdata <= {24'h000000, capture_compare_ctrl_reg};
        end else if (haddr[4:2] == `TMR_IDX_OUTC) begin
          hrdata <= {24'h000000, output_control_reg};
        end else if (haddr[4:2] == `TMR_IDX_PRESC) begin
          hrdata <= {24'h000000, prescaler_reg};
        end else begin
          hrdata <= {28'h0000000, os_state == tmr_pkg::OS_ACTIVE, os_state != tmr_pkg::OS_IDLE, run, overflow_flag};
        end
      end
    end
  end

  a_ovf_on_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> overflow_flag && main_counter == 16'h0000)
    else $error("wrap did not set overflow");
  a_ovf_clear_lost: assert property (@(posedge hclk) disable iff (!hresetn)
    (ovf_evt ##1 ovf_clr) |=> overflow_flag)
    else $error("overflow clear took effect too early");
  a_stop_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    !run |=> main_counter == 16'h0000 && !match_a_irq && os_state == tmr_pkg::OS_IDLE)
    else $error("stopped timer moved");
  a_start_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && tick && !os_fire && run_mode == tmr_pkg::RUN_FREE && !trg_v) |=>
      main_counter == $past(main_counter) + 16'h0001)
    else $error("counter did not advance");
  a_retrig_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (os_state == tmr_pkg::OS_ACTIVE && trg_v && !mt_a && !mt_b
      && (run_mode == tmr_pkg::RUN_FREE || run_mode == tmr_pkg::RUN_EDGE_CLR))
      |=> os_state == tmr_pkg::OS_ACTIVE && main_counter != 16'h0000)
    else $error("trigger during pulse restarted counter");
  a_pulse_window: assert property (@(posedge hclk) disable iff (!hresetn)
    (os_state == tmr_pkg::OS_WAIT && compare_reg_b < compare_reg_a && mt_b && run)
      |=> pulse_out_pin == output_control_reg[`TMR_OUT_EN] && os_state == tmr_pkg::OS_ACTIVE)
    else $error("pulse not started at lower match");
  a_no_oneshot_mc: assert property (@(posedge hclk) disable iff (!hresetn)
    (run_mode == tmr_pkg::RUN_MATCH_CLR && os_state == tmr_pkg::OS_IDLE) |=> os_state == tmr_pkg::OS_IDLE)
    else $error("one-shot started in match-clear mode");
  a_no_pin_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_sel == tmr_pkg::CLK_PIN_EDGE && !wr_hit(wr_pend, wr_idx, `TMR_IDX_CMP_B))
      |=> compare_reg_b == $past(compare_reg_b))
    else $error("capture from count clock pin");
  a_capture_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_b |=> compare_reg_b == $past(main_counter))
    else $error("capture lost to bus access");
  a_cap_event_late: assert property (@(posedge hclk) disable iff (!hresetn)
    (cap_a && capture_compare_ctrl_reg[`TMR_CRC_CAP_A]) |=> !match_a_irq)
    else $error("capture event not delayed");
endmodule

// *** rtl/tmr_consts.svh ***
// offsets, field positions, reset values and timing constants of the 16-bit timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// register indices; byte address is index times four
`define TMR_IDX_COUNT   3'h0
`define TMR_IDX_CMP_A   3'h1
`define TMR_IDX_CMP_B   3'h2
`define TMR_IDX_MODE    3'h3
`define TMR_IDX_CRC     3'h4
`define TMR_IDX_OUTC    3'h5
`define TMR_IDX_PRESC   3'h6
`define TMR_IDX_STATUS  3'h7
// field positions
`define TMR_RUN_LO      2
`define TMR_RUN_HI      3
`define TMR_CRC_CAP_A   0
`define TMR_CRC_CAP_B   1
`define TMR_OUT_EN      0
`define TMR_OUT_OS_EN   4
`define TMR_OUT_SOFT    6
`define TMR_PRE_CLK_LO  0
`define TMR_PRE_CLK_HI  1
`define TMR_PRE_ES_LO   4
`define TMR_PRE_ES_HI   5
`define TMR_PRE_ESB_LO  6
`define TMR_PRE_ESB_HI  7
`define TMR_ST_OVF      0
// values
`define TMR_RUN_STOP    2'h0
`define TMR_CNT_MAX     16'hFFFF
`define TMR_CMP_RESET   16'h0000
`define TMR_DIV4_LAST   4'h3
`define TMR_DIV16_LAST  4'hF
`endif

// *** rtl/tmr_pkg.sv ***
// types shared by the 16-bit timer design
package tmr_pkg;
  typedef enum logic [1:0] {RUN_STOP, RUN_FREE, RUN_EDGE_CLR, RUN_MATCH_CLR} tmr_run_t;
  typedef enum logic [1:0] {CLK_FX, CLK_DIV4, CLK_DIV16, CLK_PIN_EDGE} tmr_clk_t;
  typedef enum {OS_IDLE, OS_WAIT, OS_ACTIVE} tmr_os_t;
endpackage

// *** testbench/tmr_pin_src.sv ***
// model of the external trigger and capture signal sources
`timescale 1ns/100ps
module tmr_pin_src (
  input  wire logic hclk,
  output logic      trigger_in_pin,
  output logic      capture_in_b_pin
);
  initial begin
    trigger_in_pin = 1'b0;
    capture_in_b_pin = 1'b0;
  end
  // sel 1 picks the capture pin; the level then stays until the next call
  // hold is normally long enough for capture a hold of 0 gives a one-cycle glitch
  task automatic drive(input logic sel, input logic lvl, input int hold);
    @(posedge hclk);
    if (sel) begin
      capture_in_b_pin <= lvl;
    end else begin
      trigger_in_pin <= lvl;
    end
    repeat (hold) @(posedge hclk);
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the 16-bit timer
`timescale 1ns/100ps
`include "tmr_consts.svh"
module testbench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        trigger_in_pin;
  logic        capture_in_b_pin;
  logic        pulse_out_pin;
  logic        match_a_irq;
  logic        match_b_irq;
  logic [31:0] rd;
  logic [31:0] c0;
  int          fails;
  int          checks;

  tmr_timer16 dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (3'h2),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hrdata           (hrdata),
    .hresp            (hresp),
    .trigger_in_pin   (trigger_in_pin),
    .capture_in_b_pin (capture_in_b_pin),
    .pulse_out_pin    (pulse_out_pin),
    .match_a_irq      (match_a_irq),
    .match_b_irq      (match_b_irq)
  );
  tmr_pin_src src (
    .hclk             (hclk),
    .trigger_in_pin   (trigger_in_pin),
    .capture_in_b_pin (capture_in_b_pin)
  );

  // 100 MHz clock
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string what);
    checks++;
    if (!(got >= lo && got <= hi)) begin
      fails++;
      $display("[FAIL] %0t %s got %h", $time, what, got);
    end
  endtask

  // wait for an edge with hready high, with no cycle limit
  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {27'h0, i, 2'h0}, d, x);
  endtask
  task automatic rdv(input logic [2:0] i, output logic [31:0] d);
    bus(1'b0, {27'h0, i, 2'h0}, 32'h0, d);
  endtask
  // counts the cycles the pulse stays high; 0 if it never rises
  task automatic pulse_width(input int exp);
    int w;
    w = 0;
    for (int n = 0; n < 300 && pulse_out_pin !== 1'b1; n++) @(posedge hclk);
    while (pulse_out_pin === 1'b1 && w < 300) begin
      @(posedge hclk);
      w++;
    end
    check(w, exp, "pulse width");
  endtask
  // compare values are rewritten after every stop since they may be lost
  task automatic setup(input logic [31:0] a, input logic [31:0] b, input logic [31:0] pre);
    wr(`TMR_IDX_MODE, 32'h0);
    wr(`TMR_IDX_PRESC, pre);
    wr(`TMR_IDX_CMP_A, a);
    wr(`TMR_IDX_CMP_B, b);
  endtask

  task automatic t_reset();
    wr(3'h0, 32'h0);
    bus(1'b1, 32'h24, 32'hFFFF, rd);
    bus(1'b0, 32'h20, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      rdv(i[2:0], rd);
      check(rd, 32'h0, "reset value");
    end
    check({31'h0, pulse_out_pin}, 32'h0, "pulse at reset");
    check({31'h0, hresp}, 32'h0, "okay response");
    $display("test reset done");
  endtask

  task automatic t_free();
    setup(32'h100, 32'h80, 32'h0);
    wr(`TMR_IDX_MODE, 32'h4);
    rdv(`TMR_IDX_COUNT, c0);
    rdv(`TMR_IDX_COUNT, rd);
    check_in(c0, 32'h1, 32'h3, "count after start");
    check(rd - c0, 32'h3, "count step");
    wr(`TMR_IDX_MODE, 32'h0);
    rdv(`TMR_IDX_COUNT, rd);
    check(rd, 32'h0, "count after stop");
    $display("test free-running done");
  endtask

  task automatic t_soft();
    setup(32'd20, 32'd10, 32'h10);
    wr(`TMR_IDX_OUTC, 32'h11);
    wr(`TMR_IDX_MODE, 32'h4);
    wr(`TMR_IDX_OUTC, 32'h51);
    pulse_width(10);
    check({31'h0, match_a_irq}, 32'h1, "match a event");
    setup(32'd10, 32'd20, 32'h10);
    wr(`TMR_IDX_MODE, 32'h4);
    wr(`TMR_IDX_OUTC, 32'h51);
    pulse_width(10);
    check({31'h0, match_b_irq}, 32'h1, "match b event");
    src.drive(1'b0, 1'b1, 1);
    pulse_width(10);
    rdv(`TMR_IDX_COUNT, c0);
    rdv(`TMR_IDX_COUNT, rd);
    check(rd - c0, 32'h3, "count after pulse");
    $display("test soft one-shot done");
  endtask

  // rising, falling, then both edges; a second edge arrives during the last pulse
  task automatic t_ext();
    logic [1:0] es[3];
    es = '{2'h1, 2'h0, 2'h2};
    src.drive(1'b0, 1'b0, 8);
    for (int k = 0; k < 3; k++) begin
      setup(32'd40, 32'd10, {26'h0, es[k], 4'h0});
      wr(`TMR_IDX_MODE, 32'h8);
      src.drive(1'b0, (k != 1), 1);
      fork
        if (k == 2) begin
          repeat (20) @(posedge hclk);
          src.drive(1'b0, 1'b0, 1);
        end
        pulse_width(30);
      join
    end
    wr(`TMR_IDX_MODE, 32'hC);
    src.drive(1'b0, 1'b1, 1);
    pulse_width(0);
    wr(`TMR_IDX_MODE, 32'h0);
    src.drive(1'b0, 1'b0, 8);
    wr(`TMR_IDX_MODE, 32'h8);
    pulse_width(0);
    $display("test external one-shot done");
  endtask

  task automatic t_cap();
    setup(32'h1, 32'h1234, 32'h40);
    wr(`TMR_IDX_CRC, 32'h1);
    wr(`TMR_IDX_MODE, 32'h4);
    rdv(`TMR_IDX_COUNT, c0);
    src.drive(1'b1, 1'b1, 1);
    for (int n = 0; n < 50 && match_a_irq !== 1'b1; n++) @(posedge hclk);
    check({31'h0, match_a_irq}, 32'h1, "capture event");
    rdv(`TMR_IDX_CMP_A, rd);
    check_in(rd, c0, c0 + 32'd60, "captured count");
    rdv(`TMR_IDX_CMP_B, rd);
    check(rd, 32'h1234, "b after counter read");
    $display("test capture done");
  endtask

  task automatic t_count();
    setup(32'hFFFF, 32'h55AA, 32'h13);
    wr(`TMR_IDX_CRC, 32'h2);
    wr(`TMR_IDX_MODE, 32'h4);
    repeat (3) begin
      src.drive(1'b0, 1'b1, 8);
      src.drive(1'b0, 1'b0, 8);
    end
    src.drive(1'b0, 1'b1, 0);
    src.drive(1'b0, 1'b0, 8);
    rdv(`TMR_IDX_COUNT, rd);
    check(rd, 32'h3, "pin edge count");
    rdv(`TMR_IDX_CMP_B, rd);
    check(rd, 32'h55AA, "no capture from count pin");
    $display("test pin counting done");
  endtask

  task automatic t_ovf();
    setup(32'hFFFF, 32'h10, 32'h0);
    wr(`TMR_IDX_MODE, 32'hC);
    repeat (65576) @(posedge hclk);
    rdv(`TMR_IDX_STATUS, rd);
    check({31'h0, rd[0]}, 32'h1, "overflow set");
    wr(`TMR_IDX_STATUS, 32'h1);
    rdv(`TMR_IDX_STATUS, rd);
    check({31'h0, rd[0]}, 32'h0, "overflow cleared");
    wr(`TMR_IDX_MODE, 32'h0);
    $display("test overflow done");
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the overflow wait dominates the run
  initial begin
    #900000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fails = 0;
    checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_free();
    t_soft();
    t_ext();
    t_cap();
    t_count();
    t_ovf();
    end_of_test();
  end
endmodule
